// >>> xmove_pkg.sv
package xmove_pkg;

	////////////////////////////////////////////////////////////////////////
	// Machine cycle states, one-hot
	typedef enum logic [3:0]
	{
		STATE_ONE   = 4'h1,
		STATE_TWO   = 4'h2,
		STATE_THREE = 4'h4,
		STATE_FOUR  = 4'h8
	} phase_e;

	// Instruction sequencer states, one-hot
	typedef enum logic [2:0]
	{
		SEQ_FETCH  = 3'h1,
		SEQ_EXEC   = 3'h2,
		SEQ_ACCESS = 3'h4
	} seq_e;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS    = 5;
	localparam int unsigned STATES_PER_CYCLE = 4;
	localparam logic [3:0]  XMOVE_BASE_CYCLES = 4'h2;
	localparam logic [3:0]  SINGLE_CYCLE     = 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Register indexes (byte address is four times the index)
	localparam logic [9:0]  CLOCK_CONTROL_INDEX = 10'h080;
	localparam logic [9:0]  FIRST_POINTER_INDEX = 10'h081;
	localparam logic [9:0]  SECOND_POINTER_INDEX = 10'h082;
	localparam logic [9:0]  STATUS_INDEX        = 10'h083;
	localparam logic [9:0]  POINTER_SELECT_INDEX = 10'h086;

	// Field positions and reset values
	localparam int unsigned STRETCH_LSB   = 0;
	localparam int unsigned STRETCH_W     = 3;
	localparam int unsigned SELECT_BIT    = 0;
	localparam logic [2:0]  STRETCH_RESET = 3'h1;
	localparam logic        SELECT_RESET  = 1'b0;
	localparam logic [15:0] POINTER_RESET = 16'h0000;

	// AHB-Lite encodings
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'b0;

endpackage

// >>> machine_phase.sv
module machine_phase
	import xmove_pkg::*;
(
	input  wire logic hclk,
	input  wire logic hresetn,
	output phase_e    state_q
);

	////////////////////////////////////////////////////////////////////////
	// four ordered states
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_q <= STATE_ONE;
		else
		begin
			case (state_q)
				STATE_ONE:   state_q <= STATE_TWO;
				STATE_TWO:   state_q <= STATE_THREE;
				STATE_THREE: state_q <= STATE_FOUR;
				STATE_FOUR:  state_q <= STATE_ONE;
				default:     state_q <= STATE_ONE;
			endcase
		end
	end

endmodule

// >>> instruction_timing_xdata_addressing.sv
module instruction_timing_xdata_addressing
	import xmove_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  indirect_working_register,
	input  wire logic [7:0]  port2_value,
	input  wire logic        inc_pointer_select,
	output logic             fetch_q,
	output logic             instr_start_q,
	output logic             cpu_hold_q,
	output logic [15:0]      xaddr_q,
	output logic             xrd_n_q,
	output logic             xwr_n_q,
	output logic             addr_latch_q
);

	phase_e           state_q;
	seq_e             seq_q;
	logic [3:0]       mc_q;
	logic [3:0]       len_q;
	logic [2:0]       stretch_field;
	logic [2:0]       move_stretch_q;
	logic             move_write_q;
	logic             pointer_select_bit;
	logic [15:0]      first_data_pointer;
	logic [15:0]      second_data_pointer;
	logic             wr_pend_q;
	logic [9:0]       wr_index_q;
	logic [9:0]       addr_index;
	logic             addr_phase;
	logic [31:0]      read_value;
	logic [3:0]       len_now;
	logic             strobe_on;
	logic [15:0]      selected_pointer;

	////////////////////////////////////////////////////////////////////////
	// Opcode decode

	function automatic logic [1:0] op_bytes(input logic [7:0] op);
		logic [3:0] hi;
		logic [3:0] lo;
		logic [1:0] n;
		hi = op[7:4];
		lo = op[3:0];
		n = 2'd1;
		case (lo)
			4'h0:
				if (hi >= 4'h1 && hi <= 4'h3 || hi == 4'h9)
					n = 2'd3;
				else if (hi != 4'h0 && hi < 4'hE)
					n = 2'd2;
			4'h1:
				n = 2'd2;
			4'h2:
				if (hi <= 4'h1)
					n = 2'd3;
				else if (hi >= 4'h4 && hi <= 4'hD)
					n = 2'd2;
			4'h3:
				if (hi >= 4'h4 && hi <= 4'h6)
					n = 2'd3;
			4'h4:
				if (hi == 4'hB)
					n = 2'd3;
				else if (hi >= 4'h2 && hi <= 4'h9 && hi != 4'h8)
					n = 2'd2;
			4'h5:
				if (hi == 4'h7 || hi == 4'h8 || hi == 4'hB || hi == 4'hD)
					n = 2'd3;
				else if (hi != 4'hA)
					n = 2'd2;
			default:
				if (hi == 4'hB)
					n = 2'd3;
				else if (hi == 4'h7 || hi == 4'h8 || hi == 4'hA)
					n = 2'd2;
				else if (hi == 4'hD && lo >= 4'h8)
					n = 2'd2;
		endcase
		return n;
	endfunction

	function automatic logic is_branch(input logic [7:0] op);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		return (lo == 4'h1)
			|| (lo == 4'h0 && hi >= 4'h1 && hi <= 4'h8)
			|| (lo == 4'h2 && hi <= 4'h1)
			|| (lo >= 4'h4 && hi == 4'hB)
			|| (lo == 4'h5 && hi == 4'hD)
			|| (lo >= 4'h8 && hi == 4'hD);
	endfunction

	function automatic logic is_xmove(input logic [7:0] op);
		return op[7:5] == 3'b111 && (op[3:0] == 4'h0 || op[3:1] == 3'b001);
	endfunction

	// Machine cycles of a non-move opcode
	function automatic logic [3:0] op_cycles(input logic [7:0] op);
		logic [3:0] c;
		c = {2'b00, op_bytes(op)};
		case (op)
			8'h22, 8'h32, 8'h83, 8'h93, 8'hA3:
				c = 4'h2;
			8'h84, 8'hA4:
				c = 4'h5;
			default:
				if (is_branch(op))
					c = c + 4'h1;
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State generator

	machine_phase u_phase
	(
		.hclk    (hclk),
		.hresetn (hresetn),
		.state_q (state_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Instruction sequencer

	always_comb
	begin
		if (is_xmove(opcode))
			len_now = {1'b0, stretch_field} + XMOVE_BASE_CYCLES;
		else
			len_now = op_cycles(opcode);
	end

	// move ends only after last cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			seq_q <= SEQ_FETCH;
			mc_q  <= 4'h0;
			len_q <= SINGLE_CYCLE;
		end
		else if (state_q == STATE_FOUR)
		begin
			case (seq_q)
				SEQ_FETCH:
					if (len_now != SINGLE_CYCLE)
					begin
						mc_q  <= 4'h1;
						len_q <= len_now;
						seq_q <= is_xmove(opcode) ? SEQ_ACCESS : SEQ_EXEC;
					end
				SEQ_EXEC, SEQ_ACCESS:
					if (mc_q == len_q - 4'h1)
					begin
						mc_q  <= 4'h0;
						seq_q <= SEQ_FETCH;
					end
					else
						mc_q <= mc_q + 4'h1;
				default:
				begin
					mc_q  <= 4'h0;
					seq_q <= SEQ_FETCH;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External move address

	assign selected_pointer = pointer_select_bit ? second_data_pointer
		: first_data_pointer;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			xaddr_q        <= 16'h0000;
			move_write_q   <= 1'b0;
			move_stretch_q <= STRETCH_RESET;
		end
		else if (state_q == STATE_FOUR && seq_q == SEQ_FETCH
			&& is_xmove(opcode))
		begin
			move_write_q   <= opcode[4];
			move_stretch_q <= stretch_field;
			if (opcode[1])
				xaddr_q <= {port2_value, indirect_working_register};
			else
				xaddr_q <= selected_pointer;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strobes and timing outputs

	always_comb
	begin
		strobe_on = 1'b0;
		if (seq_q == SEQ_ACCESS)
		begin
			if (move_stretch_q == 3'h0)
				strobe_on = mc_q == 4'h1 && (state_q == STATE_THREE
					|| state_q == STATE_FOUR);
			else
				strobe_on = mc_q >= 4'h1
					&& mc_q <= {1'b0, move_stretch_q};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			xrd_n_q <= 1'b1;
			xwr_n_q <= 1'b1;
		end
		else
		begin
			xrd_n_q <= !(strobe_on && !move_write_q);
			xwr_n_q <= !(strobe_on && move_write_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fetch_q       <= 1'b0;
			instr_start_q <= 1'b0;
			cpu_hold_q    <= 1'b0;
		end
		else
		begin
			fetch_q <= state_q == STATE_ONE && seq_q != SEQ_ACCESS;
			instr_start_q <= state_q == STATE_ONE && seq_q == SEQ_FETCH;
			cpu_hold_q <= seq_q == SEQ_ACCESS && mc_q >= 4'h2;
		end
	end

	always_ff @(negedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			addr_latch_q <= 1'b0;
		else
			addr_latch_q <= seq_q == SEQ_ACCESS && mc_q == 4'h1
				&& state_q == STATE_ONE;
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
	assign addr_index = haddr[11:2];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q  <= 1'b0;
			wr_index_q <= 10'h000;
		end
		else
		begin
			wr_pend_q  <= addr_phase && hwrite && hsize == 3'h2
				&& haddr[31:12] == 20'h00000 && haddr[1:0] == 2'h0;
			wr_index_q <= addr_index;
		end
	end

	always_comb
	begin
		read_value = 32'h00000000;
		if (haddr[31:12] == 20'h00000 && haddr[1:0] == 2'h0)
		begin
			case (addr_index)
				CLOCK_CONTROL_INDEX:
					read_value[STRETCH_LSB +: STRETCH_W] = stretch_field;
				FIRST_POINTER_INDEX:
					read_value[15:0] = first_data_pointer;
				SECOND_POINTER_INDEX:
					read_value[15:0] = second_data_pointer;
				STATUS_INDEX:
					read_value[10:0] = {seq_q, mc_q, state_q};
				POINTER_SELECT_INDEX:
					read_value[SELECT_BIT] = pointer_select_bit;
				default:
					read_value = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
			if (addr_phase && !hwrite)
				hrdata <= read_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			stretch_field <= STRETCH_RESET;
		else if (wr_pend_q && wr_index_q == CLOCK_CONTROL_INDEX)
			stretch_field <= hwdata[STRETCH_LSB +: STRETCH_W];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pointer_select_bit <= SELECT_RESET;
		else if (wr_pend_q && wr_index_q == POINTER_SELECT_INDEX)
			pointer_select_bit <= hwdata[SELECT_BIT];
		else if (inc_pointer_select)
			pointer_select_bit <= !pointer_select_bit;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			first_data_pointer  <= POINTER_RESET;
			second_data_pointer <= POINTER_RESET;
		end
		else if (wr_pend_q)
		begin
			if (wr_index_q == FIRST_POINTER_INDEX)
				first_data_pointer <= hwdata[15:0];
			if (wr_index_q == SECOND_POINTER_INDEX)
				second_data_pointer <= hwdata[15:0];
		end
	end

endmodule

// >>> xmove_properties.sv
module xmove_properties
	import xmove_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        fetch_q,
	input wire logic        instr_start_q,
	input wire logic        cpu_hold_q,
	input wire logic [15:0] xaddr_q,
	input wire logic        xrd_n_q,
	input wire logic        xwr_n_q,
	input wire logic        addr_latch_q
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic strobe;
	assign strobe = !xrd_n_q || !xwr_n_q;

	////////////////////////////////////////////////////////////////////////
	property p_fetch_period;
		fetch_q |=> !fetch_q [*3];
	endproperty
	a_fetch_period: assert property (p_fetch_period)
		else $error("fetch twice in one machine cycle");
	property p_start_space;
		instr_start_q |=> !instr_start_q [*3];
	endproperty
	a_start_space: assert property (p_start_space)
		else $error("instruction shorter than four clocks");
	property p_start_fetch;
		instr_start_q |-> fetch_q;
	endproperty
	a_start_fetch: assert property (p_start_fetch)
		else $error("instruction start without fetch");
	property p_hold_quiet;
		cpu_hold_q |-> !fetch_q && !instr_start_q;
	endproperty
	a_hold_quiet: assert property (p_hold_quiet)
		else $error("fetch during stretched move");
	property p_one_strobe;
		xrd_n_q || xwr_n_q;
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("read and write strobes low together");
	property p_addr_hold;
		strobe ##1 strobe |-> $stable(xaddr_q);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved under strobe");
	property p_latch_lead;
		$rose(addr_latch_q) |-> ##[1:5] strobe;
	endproperty
	a_latch_lead: assert property (p_latch_lead)
		else $error("no strobe after address latch");
	property p_strobe_quiet;
		strobe |-> !fetch_q;
	endproperty
	a_strobe_quiet: assert property (p_strobe_quiet)
		else $error("fetch under strobe");
	property p_hold_after;
		$rose(cpu_hold_q) |-> $past(strobe);
	endproperty
	a_hold_after: assert property (p_hold_after)
		else $error("hold without access");
endmodule

bind instruction_timing_xdata_addressing xmove_properties u_props
(
	.hclk          (hclk),
	.hresetn       (hresetn),
	.fetch_q       (fetch_q),
	.instr_start_q (instr_start_q),
	.cpu_hold_q    (cpu_hold_q),
	.xaddr_q       (xaddr_q),
	.xrd_n_q       (xrd_n_q),
	.xwr_n_q       (xwr_n_q),
	.addr_latch_q  (addr_latch_q)
);

// >>> xmem_model.sv
module xmem_model
(
	input  wire logic        hclk,
	input  wire logic [15:0] xaddr,
	input  wire logic        xrd_n,
	input  wire logic        xwr_n,
	output logic [15:0]      last_addr_q,
	output logic             last_wr_q,
	output logic [7:0]       width_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	initial
	begin
		cnt_q = 8'h00;
		width_q = 8'h00;
		last_addr_q = 16'h0000;
		last_wr_q = 1'b0;
	end
	always @(posedge hclk)
	begin
		if (!xrd_n || !xwr_n)
		begin
			cnt_q <= cnt_q + 8'h01;
			last_addr_q <= xaddr;
			last_wr_q <= !xwr_n;
		end
		else if (cnt_q != 8'h00)
		begin
			width_q <= cnt_q;
			cnt_q <= 8'h00;
		end
	end
endmodule

// >>> test_instruction_timing_xdata_addressing.sv
module test_instruction_timing_xdata_addressing
	import xmove_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e); \
		end \
	end

	typedef struct {logic [7:0] op; logic [2:0] st; int cyc; logic [7:0] w;} row_s;
	row_s rows [17] = '{
		'{8'h9A, 3'h7, 1, 8'h00}, '{8'h94, 3'h7, 2, 8'h00},
		'{8'hC5, 3'h7, 2, 8'h00}, '{8'h65, 3'h7, 2, 8'h00},
		'{8'h22, 3'h7, 2, 8'h00}, '{8'h63, 3'h7, 3, 8'h00},
		'{8'h02, 3'h7, 4, 8'h00}, '{8'h84, 3'h7, 5, 8'h00},
		'{8'hE0, 3'h0, 2, 8'h02}, '{8'hE0, 3'h1, 3, 8'h04},
		'{8'hF0, 3'h2, 4, 8'h08}, '{8'hE0, 3'h3, 5, 8'h0C},
		'{8'hF0, 3'h4, 6, 8'h10}, '{8'hE0, 3'h5, 7, 8'h14},
		'{8'hF0, 3'h6, 8, 8'h18}, '{8'hE0, 3'h7, 9, 8'h1C},
		'{8'h9A, 3'h0, 1, 8'h00}};
	logic        hclk, hresetn, hsel, hwrite, inc_pointer_select;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  opcode, irw, p2, m_width;
	logic        hreadyout, hresp, fetch_q, instr_start_q, cpu_hold_q, m_wr;
	logic        xrd_n_q, xwr_n_q, addr_latch_q;
	logic [15:0] xaddr_q, m_addr;
	int          n_fail, check_count, clks;

	instruction_timing_xdata_addressing uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opcode(opcode),
		.indirect_working_register(irw), .port2_value(p2),
		.inc_pointer_select(inc_pointer_select), .fetch_q(fetch_q),
		.instr_start_q(instr_start_q), .cpu_hold_q(cpu_hold_q),
		.xaddr_q(xaddr_q), .xrd_n_q(xrd_n_q), .xwr_n_q(xwr_n_q),
		.addr_latch_q(addr_latch_q));
	xmem_model u_mem (.hclk(hclk), .xaddr(xaddr_q), .xrd_n(xrd_n_q),
		.xwr_n(xwr_n_q), .last_addr_q(m_addr), .last_wr_q(m_wr),
		.width_q(m_width));

	always #2.5 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////
	task wait_ready;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready;
		r = hrdata;
	endtask
	task pulse_inc;
		@(posedge hclk);
		inc_pointer_select <= 1'b1;
		@(posedge hclk);
		inc_pointer_select <= 1'b0;
	endtask
	task next_start(output int n);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (instr_start_q !== 1'b1);
	endtask
	task measure(input logic [7:0] op);
		@(posedge hclk);
		opcode <= op;
		repeat (3) next_start(clks);
		@(posedge hclk);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{hclk, hresetn, hsel, hwrite, inc_pointer_select} = 5'h00;
		{haddr, hwdata, htrans, opcode, irw, p2} = 0;
		hsize = 3'h2;
		n_fail = 0;
		check_count = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 17; i++)
		begin
			bus(1'b1, 32'h0000_0200, {29'h0, rows[i].st});
			measure(rows[i].op);
			`CHK(clks, rows[i].cyc * 4);
			if (rows[i].w != 8'h00)
				`CHK(m_width, rows[i].w);
		end
		// Reset again in mid-run, then register checks
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0000_0200, 32'h0);
		`CHK(r, 32'h0000_0001);
		bus(1'b0, 32'h0000_020C, 32'h0);
		`CHK(r[10:4], 7'h10);
		bus(1'b0, 32'h0000_0218, 32'h0);
		`CHK(r, 32'h0000_0000);
		bus(1'b1, 32'h0000_0218, 32'hFF);
		bus(1'b0, 32'h0000_0218, 32'h0);
		`CHK(r, 32'h0000_0001);
		`CHK(hresp, HRESP_OKAY);
		pulse_inc;
		bus(1'b0, 32'h0000_0218, 32'h0);
		`CHK(r, 32'h0000_0000);
		bus(1'b1, 32'h0000_0300, 32'hFF);
		bus(1'b0, 32'h0000_0300, 32'h0);
		`CHK(r, 32'h0000_0000);
		bus(1'b1, 32'h0000_0204, 32'h1234);
		bus(1'b1, 32'h0000_0208, 32'hABCD);
		measure(8'hF0);
		`CHK(m_addr, 16'h1234);
		`CHK(m_wr, 1'b1);
		pulse_inc;
		measure(8'hE0);
		`CHK(m_addr, 16'hABCD);
		`CHK(m_wr, 1'b0);
		irw <= 8'hC3;
		p2 <= 8'h5A;
		measure(8'hE2);
		`CHK(m_addr, 16'h5AC3);
		irw <= 8'h3C;
		measure(8'hF3);
		`CHK(m_addr, 16'h5A3C);
		test_done;
	end
	initial
	begin
		#100000;
		n_fail++;
		test_done;
	end
endmodule
